// >>> design/wireless_rx_irq_enable_bank.sv
// Purpose: Interrupt status, per-role enable masks and coil offset readout.
// Assumes: Classic Wishbone slave, 32-bit data, byte data in bits 7:0.
// Notes:   Events arrive as one-cycle pulses on the same clock.
// Operation
// R1 - Enabled source may raise the interrupt.
// R2 - Disabled source is blocked, enable still accessible.
// R3 - Separate receive and transmit enable maps.
// R4 - Transmit enable defaults per documented bits.
// R5 - Horizontal offset read-only signed byte.
// R6 - Offset follows measured coil position.
// R7 - Software treats offset as relative only.
// R8 - Receive upper byte carries extra enables.
// R9 - Status flag set on its event.
// R10 - Interrupt is OR of status AND enable.
`timescale 1ns/10ps
module wireless_rx_irq_enable_bank
  import irq_enable_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [31:0] i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_tx_role,
  input  wire logic [7:0]  i_coil_offset_x,
  input  wire logic [23:0] i_event,
  output logic             o_irq
);

  typedef struct packed {
    logic [23:0] status;
    logic [23:0] rx_mask;
    logic [7:0]  tx_mask_low;
    logic        tx_mask_csp;
    logic        role_meta;
    logic        role;
    logic [7:0]  coil_meta;
    logic [7:0]  coil_x;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
  } state_t;

  localparam state_t STATE_RST = '{
    status:      STATUS_RST,
    rx_mask:     {RX_MASK_UPPER_RST, RX_MASK_SEC_RST, RX_MASK_LOW_RST},
    tx_mask_low: TX_MASK_LOW_RST,
    tx_mask_csp: TX_MASK_CSP_RST,
    role_meta:   1'b0,
    role:        1'b0,
    coil_meta:   COIL_X_RST,
    coil_x:      COIL_X_RST,
    ack:         1'b0,
    dat:         32'h00000000,
    irq:         1'b0
  };

  state_t      state_q;
  state_t      state_d;
  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic [23:0] tx_mask;
  logic [23:0] active_mask;
  logic [23:0] clear_bits;
  logic [7:0]  rd_byte;

  assign idx = i_wb_adr[ADR_IDX_MSB:ADR_IDX_LSB];
  // A new request is taken only while no answer is standing.
  assign req = i_wb_cyc & i_wb_stb & ~state_q.ack;
  assign wr  = req & i_wb_we & i_wb_sel[0];

  // The transmit map has only the low byte and one bit of the second.
  assign tx_mask = {8'h00, 7'h00, state_q.tx_mask_csp, state_q.tx_mask_low};
  // The synchronised role picks which enable map gates the status.
  assign active_mask = state_q.role ? tx_mask : state_q.rx_mask; // R3

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_STATUS_LOW:   rd_byte = state_q.status[7:0];
      IDX_STATUS_SEC:   rd_byte = state_q.status[15:8];
      IDX_STATUS_UPPER: rd_byte = state_q.status[23:16];
      IDX_MASK_LOW: begin
        rd_byte = state_q.role ? state_q.tx_mask_low
                               : state_q.rx_mask[7:0];
      end
      IDX_MASK_SEC: begin
        rd_byte = state_q.role ? {7'h00, state_q.tx_mask_csp}
                               : state_q.rx_mask[15:8];
      end
      IDX_MASK_UPPER: begin
        // The transmit spare byte is reserved and reads as zero.
        rd_byte = state_q.role ? TX_MASK_SPARE_RST
                               : state_q.rx_mask[23:16]; // R8
      end
      IDX_COIL_X:       rd_byte = state_q.coil_x; // R5
      IDX_ROLE:         rd_byte = {7'h00, state_q.role};
      default:          rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    clear_bits = 24'h000000;
    if (wr) begin
      case (idx)
        IDX_STATUS_LOW:   clear_bits = {16'h0000, i_wb_dat[7:0]};
        IDX_STATUS_SEC:   clear_bits = {8'h00, i_wb_dat[7:0], 8'h00};
        IDX_STATUS_UPPER: clear_bits = {i_wb_dat[7:0], 16'h0000};
        default:          clear_bits = 24'h000000;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    // Two flops keep pin levels from the analog side off the logic.
    state_d.role_meta = i_tx_role;
    state_d.role      = state_q.role_meta;
    state_d.coil_meta = i_coil_offset_x;
    state_d.coil_x    = state_q.coil_meta; // R6
    // An event in the same cycle as its clear wins, so none is lost.
    state_d.status = (state_q.status & ~clear_bits) | i_event; // R9
    if (wr) begin
      case (idx)
        IDX_MASK_LOW: begin
          if (state_q.role) begin
            state_d.tx_mask_low = i_wb_dat[7:0];
          end else begin
            state_d.rx_mask[7:0] = i_wb_dat[7:0];
          end
        end
        IDX_MASK_SEC: begin
          if (state_q.role) begin
            state_d.tx_mask_csp = i_wb_dat[TX_CSP_BIT];
          end else begin
            state_d.rx_mask[15:8] = i_wb_dat[7:0];
          end
        end
        IDX_MASK_UPPER: begin
          if (!state_q.role) begin
            state_d.rx_mask[23:16] = i_wb_dat[7:0]; // R8
          end
        end
        default: begin
        end
      endcase
    end
    // Every access, mapped or not, is answered one cycle later.
    state_d.ack = req;
    state_d.dat = state_q.dat;
    if (req) begin
      state_d.dat = {24'h000000, rd_byte};
    end
    state_d.irq = |(state_q.status & active_mask); // R1 R2 R10
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= STATE_RST; // R4
    end else begin
      state_q <= state_d;
    end
  end

  assign o_wb_ack = state_q.ack;
  assign o_wb_dat = state_q.dat;
  assign o_irq    = state_q.irq;

  // The checks below watch registered state and outputs, and several also
  // sample the bus request, address, write data and event inputs directly.

  a_irq_enabled_source: assert property ( // R1
    @(posedge i_clk) disable iff (i_reset)
    ((state_q.status & active_mask) != 24'h000000) |=> o_irq
  ) else $error("Enabled pending status did not raise the interrupt.");

  a_irq_masked_quiet: assert property ( // R2
    @(posedge i_clk) disable iff (i_reset)
    ((state_q.status & active_mask) == 24'h000000) |=> !o_irq
  ) else $error("Interrupt raised with no enabled status.");

  a_irq_or_and: assert property ( // R10
    @(posedge i_clk) disable iff (i_reset)
    o_irq == |($past(state_q.status) & $past(active_mask))
  ) else $error("Interrupt is not the OR of masked status.");

  a_role_map_select: assert property ( // R3
    @(posedge i_clk) disable iff (i_reset)
    state_q.role |-> active_mask[23:9] == 15'h0000
  ) else $error("Transmit role uses receive enable bits.");

  a_tx_reset_values: assert property ( // R4
    @(posedge i_clk) disable iff (i_reset)
    $past(i_reset) |-> (state_q.tx_mask_low == 8'he3 &&
                        state_q.tx_mask_csp == 1'b0)
  ) else $error("Transmit enables left reset with wrong values.");

  a_rx_upper_reset: assert property ( // R8
    @(posedge i_clk) disable iff (i_reset)
    $past(i_reset) |-> state_q.rx_mask[23:16] == 8'h7c
  ) else $error("Receive upper enables left reset wrong.");

  a_coil_read_only: assert property ( // R5
    @(posedge i_clk) disable iff (i_reset)
    (o_wb_ack && !$past(i_wb_we) && $past(idx) == IDX_COIL_X) |->
      o_wb_dat == {24'h000000, $past(state_q.coil_x)}
  ) else $error("Coil offset read returned wrong value.");

  a_coil_tracks_pin: assert property ( // R6
    @(posedge i_clk) disable iff (i_reset)
    ##2 state_q.coil_x == $past(i_coil_offset_x, 2)
  ) else $error("Coil offset does not follow its input.");

  a_event_sets_flag: assert property ( // R9
    @(posedge i_clk) disable iff (i_reset)
    (i_event != 24'h000000) |=>
      ((state_q.status & $past(i_event)) == $past(i_event))
  ) else $error("Event did not set its status flag.");

  a_ack_one_cycle: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_wb_ack |=> !o_wb_ack
  ) else $error("Acknowledge held longer than one cycle.");

  // A taken request must be answered on the very next edge, since the
  // master waits on ack and has nothing else to end the cycle.
  a_ack_after_req: assert property (
    @(posedge i_clk) disable iff (i_reset)
    req |=> o_wb_ack
  ) else $error("Taken request was not acknowledged.");

  a_read_upper_zero: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_wb_ack |-> o_wb_dat[31:8] == 24'h000000
  ) else $error("Read data carries bits above the byte.");

  // Write-one-to-clear removes a flag unless its event hits that cycle.
  a_status_w1c: assert property ( // R9
    @(posedge i_clk) disable iff (i_reset)
    (wr && idx == IDX_STATUS_LOW) |=>
      ((state_q.status[7:0] & $past(i_wb_dat[7:0]) &
        ~$past(i_event[7:0])) == 8'h00)
  ) else $error("Status flag survived its clear.");

  a_event_beats_clear: assert property ( // R9
    @(posedge i_clk) disable iff (i_reset)
    (wr && idx == IDX_STATUS_LOW &&
     (i_event[7:0] & i_wb_dat[7:0]) != 8'h00) |=>
      ((state_q.status[7:0] & $past(i_event[7:0])) == $past(i_event[7:0]))
  ) else $error("Clear in the event cycle lost the flag.");

  a_rx_mask_write: assert property ( // R2
    @(posedge i_clk) disable iff (i_reset)
    (wr && idx == IDX_MASK_LOW && !state_q.role) |=>
      state_q.rx_mask[7:0] == $past(i_wb_dat[7:0])
  ) else $error("Receive low enable write did not land.");

  a_tx_csp_write: assert property ( // R4
    @(posedge i_clk) disable iff (i_reset)
    (wr && idx == IDX_MASK_SEC && state_q.role) |=>
      state_q.tx_mask_csp == $past(i_wb_dat[TX_CSP_BIT])
  ) else $error("Transmit charge report enable write did not land.");

  // The reserved transmit byte must never leak receive enables.
  a_tx_spare_zero: assert property ( // R3
    @(posedge i_clk) disable iff (i_reset)
    (o_wb_ack && !$past(i_wb_we) && $past(state_q.role) &&
     $past(idx) == IDX_MASK_UPPER) |-> o_wb_dat == 32'h00000000
  ) else $error("Reserved transmit enable byte read nonzero.");

  a_coil_write_ignored: assert property ( // R5
    @(posedge i_clk) disable iff (i_reset)
    (wr && idx == IDX_COIL_X) |=>
      state_q.coil_x == $past(state_q.coil_meta)
  ) else $error("Write reached the read-only coil offset.");

endmodule : wireless_rx_irq_enable_bank

// >>> inc/irq_enable_pkg.sv
// Purpose: Shared constants for the wireless interrupt enable bank.
// Assumes: Register indices are word indices; byte address is four times.
// Notes:   Reset values below are the per-mode enable defaults, plus status and coil offset.
package irq_enable_pkg;

  // Register indices on the Wishbone bus (byte address = index * 4).
  localparam logic [7:0] IDX_STATUS_LOW   = 8'h30;
  localparam logic [7:0] IDX_STATUS_SEC   = 8'h31;
  localparam logic [7:0] IDX_STATUS_UPPER = 8'h32;
  localparam logic [7:0] IDX_MASK_LOW     = 8'h34;
  localparam logic [7:0] IDX_MASK_SEC     = 8'h35;
  localparam logic [7:0] IDX_MASK_UPPER   = 8'h36;
  localparam logic [7:0] IDX_COIL_X       = 8'h38;
  localparam logic [7:0] IDX_ROLE         = 8'h3f;

  // Position of the word index inside the byte address.
  localparam int ADR_IDX_LSB = 2;
  localparam int ADR_IDX_MSB = 9;

  // Receive role enable defaults, low, second and upper byte.
  localparam logic [7:0] RX_MASK_LOW_RST   = 8'hdf;
  localparam logic [7:0] RX_MASK_SEC_RST   = 8'hff;
  localparam logic [7:0] RX_MASK_UPPER_RST = 8'h7c;

  // Transmit role enable defaults.
  localparam logic [7:0] TX_MASK_LOW_RST   = 8'he3;
  localparam logic       TX_MASK_CSP_RST   = 1'b0;
  localparam logic [7:0] TX_MASK_SPARE_RST = 8'h00;

  // Field position of the charge report enable in the second byte.
  localparam int TX_CSP_BIT = 0;

  localparam logic [23:0] STATUS_RST = 24'h000000;
  localparam logic [7:0]  COIL_X_RST = 8'h00;

endpackage : irq_enable_pkg

// >>> verif/tb_wireless_rx_irq_enable_bank.sv
// Purpose: Self-checking bench for the interrupt enable bank.
// Assumes: One 100 MHz clock; registers reached over classic Wishbone.
// Notes:   Role and offset pins pass a two-flop synchroniser first.
`timescale 1ns/10ps
module tb_wireless_rx_irq_enable_bank;
  import irq_enable_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        role = 1'b0;
  logic [7:0]  coil = 8'h00;
  logic [23:0] ev = 24'h0;
  logic        irq;
  logic [7:0]  r;
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles = 0;

  wireless_rx_irq_enable_bank dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_tx_role(role), .i_coil_offset_x(coil), .i_event(ev), .o_irq(irq));

  always #5 i_clk = ~i_clk;

  task automatic report_and_stop;
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // A hang on the bus must still end in the verdict.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Ack and read data are taken at the rising edge that sees ack high;
  // the request drops right after it, so cyc and stb idle a full cycle.
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'hf;
    adr  <= {22'h0, idx, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge i_clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic pulse(input logic [23:0] e);
    @(posedge i_clk);
    ev <= e;
    @(posedge i_clk);
    ev <= 24'h0;
    repeat (3) @(negedge i_clk);
  endtask : pulse

  task automatic t_rx_reset;
    wb(1'b0, 8'h34, 8'h00, r); chk(r, 8'hdf);
    wb(1'b0, 8'h35, 8'h00, r); chk(r, 8'hff);
    wb(1'b0, 8'h36, 8'h00, r); chk(r, 8'h7c);
  endtask : t_rx_reset

  task automatic t_irq;
    pulse(24'h000002); chk({7'h0, irq}, 8'h01);
    wb(1'b0, 8'h30, 8'h00, r); chk(r, 8'h02);
    wb(1'b1, 8'h30, 8'h02, r);
    repeat (3) @(negedge i_clk); chk({7'h0, irq}, 8'h00);
    wb(1'b1, 8'h34, 8'hdd, r);
    wb(1'b0, 8'h34, 8'h00, r); chk(r, 8'hdd);
    pulse(24'h000002); chk({7'h0, irq}, 8'h00);
    pulse(24'h000100); chk({7'h0, irq}, 8'h01);
    wb(1'b1, 8'h31, 8'h01, r);
    wb(1'b1, 8'h30, 8'h02, r);
  endtask : t_irq

  task automatic t_tx;
    @(posedge i_clk);
    role <= 1'b1;
    repeat (4) @(posedge i_clk);
    wb(1'b0, 8'h34, 8'h00, r); chk(r, 8'he3);
    wb(1'b0, 8'h35, 8'h00, r); chk(r, 8'h00);
    wb(1'b0, 8'h36, 8'h00, r); chk(r, 8'h00);
    wb(1'b0, 8'h3f, 8'h00, r); chk(r, 8'h01);
    wb(1'b1, 8'h35, 8'hff, r);
    wb(1'b0, 8'h35, 8'h00, r); chk(r, 8'h01);
    @(posedge i_clk);
    role <= 1'b0;
    repeat (4) @(posedge i_clk);
    wb(1'b0, 8'h34, 8'h00, r); chk(r, 8'hdd);
  endtask : t_tx

  task automatic t_coil;
    @(posedge i_clk);
    coil <= 8'h9c;
    repeat (4) @(posedge i_clk);
    // The offset is only a relative signed reading, compared raw.
    wb(1'b0, 8'h38, 8'h00, r); chk(r, 8'h9c);
    wb(1'b1, 8'h38, 8'h55, r);
    wb(1'b0, 8'h38, 8'h00, r); chk(r, 8'h9c);
    wb(1'b0, 8'h20, 8'h00, r); chk(r, 8'h00);
  endtask : t_coil

  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    t_rx_reset();
    t_irq();
    t_tx();
    t_coil();
    report_and_stop();
  end
endmodule : tb_wireless_rx_irq_enable_bank
